// ---- hdl/eiu_regs.svh ----
// Register offsets, reset values and fixed vectors of the exception unit.
// Assumes a byte-addressed AXI4-Lite window of 256 bytes.
`ifndef EIU_REGS_SVH
`define EIU_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define EIU_AXI_AW        8
`define EIU_OFS_PSR       8'h00
`define EIU_OFS_SAVED     8'h04
`define EIU_OFS_VBASE     8'h08
`define EIU_OFS_BPADDR    8'h0c
`define EIU_OFS_RETADDR   8'h10
`define EIU_OFS_CAUSE     8'h14

// ----------------------------------------------------------------------
// Reset values, vectors and answers
// ----------------------------------------------------------------------
`define EIU_PSR_RESET     8'h0f
`define EIU_PL_MAX        4'hf
`define EIU_RESET_ADDR    32'h00000000
`define EIU_VEC_FETCH     8'h01
`define EIU_VEC_MISBR     8'h02
`define EIU_VEC_RESOP     8'h03
`define EIU_VEC_PRIV      8'h04
`define EIU_VEC_MDATA     8'h05
`define EIU_VEC_DREG      8'h06
`define EIU_VEC_BPT       8'h08
`define EIU_VEC_IRQ_BASE  8'h20
`define EIU_VEC_NMI       8'h30
`define EIU_USER_TRAP_MAX 8'h40
`define EIU_IRQ_LAST_IDX  5'h18
`define EIU_IRQ_USED      15'h5554
`define EIU_RESP_OKAY     2'h0
`define EIU_RESP_SLVERR   2'h2

`endif

// ---- hdl/eiu_pkg.sv ----
// Types shared by the exception unit files.
// Assumes nothing of its surroundings.
package eiu_pkg;

  // Status word: level, accept enable, breakpoint enable, user, nullify.
  typedef struct packed {
    logic       nullify;
    logic       user;
    logic       breakpoint_trap_enable;
    logic       em;
    logic [3:0] pl;
  } eiu_psr_s;

  // Request slots, lowest index is the highest priority; lines 14..1
  // follow the last named slot.
  typedef enum logic [4:0] {
    SRC_INIT, SRC_FETCH, SRC_MISBR, SRC_RESOP, SRC_PRIV, SRC_BPT,
    SRC_TRAP, SRC_MDATA, SRC_DREG, SRC_NMI, SRC_IRQ15
  } eiu_src_e;

  typedef logic [31:0] eiu_word_t;

endpackage

// ---- hdl/eiu_sel_if.sv ----
// Request vector and chosen slot between the unit and its arbiter.
// Assumes one clock domain; the arbiter answers combinationally.
`timescale 1ns/100ps
interface eiu_sel_if #(parameter int N = 25);
  logic [N-1:0] req;
  logic         hit;
  logic [4:0]   idx;
  modport client (output req, input hit, input idx);
  modport arb    (input req, output hit, output idx);
endinterface

// ---- hdl/eiu_sync.sv ----
// Two-flop synchroniser for a bundle of pin levels.
// Assumes each bit is an independent level from outside clk_i.
`timescale 1ns/100ps
module eiu_sync #(
  parameter int W = 17
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);
  logic [W-1:0] meta;

  for (genvar i = 0; i < W; i++) begin : g_bit
    always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
        meta[i] <= 1'b0;
        q_o[i]  <= 1'b0;
      end else begin
        meta[i] <= d_i[i];
        q_o[i]  <= meta[i];
      end
    end
  end
endmodule // eiu_sync

// ---- hdl/eiu_prio.sv ----
// Fixed-priority arbiter: the lowest requesting index wins.
// Assumes the request vector is stable within the cycle.
`timescale 1ns/100ps
module eiu_prio #(
  parameter int N = 25
) (
  eiu_sel_if.arb sel
);
  always_comb begin
    sel.hit = |sel.req;
    sel.idx = 5'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (sel.req[i]) begin
        sel.idx = 5'(i);
      end
    end
  end
endmodule // eiu_prio

// ---- hdl/eiu_top.sv ----
// Exception, trap and interrupt unit with its AXI4-Lite register slave.
// Assumes pipeline strobes are on clk_i and pins are asynchronous.
`timescale 1ns/100ps
`include "eiu_regs.svh"
module eiu_top #(
  parameter logic [14:0] IRQ_USED = `EIU_IRQ_USED,
  parameter logic        NMI_USED = 1'b0
) (
  input  wire logic                     clk_i,
  input  wire logic                     rst_n_i,
  input  wire logic [`EIU_AXI_AW-1:0]   awaddr_i,
  input  wire logic                     awvalid_i,
  output logic                          awready_o,
  input  wire logic [31:0]              wdata_i,
  input  wire logic [3:0]               wstrb_i,
  input  wire logic                     wvalid_i,
  output logic                          wready_o,
  output logic [1:0]                    bresp_o,
  output logic                          bvalid_o,
  input  wire logic                     bready_i,
  input  wire logic [`EIU_AXI_AW-1:0]   araddr_i,
  input  wire logic                     arvalid_i,
  output logic                          arready_o,
  output logic [31:0]                   rdata_o,
  output logic [1:0]                    rresp_o,
  output logic                          rvalid_o,
  input  wire logic                     rready_i,
  input  wire logic                     instr_valid_i,
  input  wire logic [31:0]              exec_pc_i,
  input  wire logic                     nullify_i,
  input  wire logic                     fetch_fault_i,
  input  wire logic                     ind_jump_i,
  input  wire logic [31:0]              jump_target_i,
  input  wire logic                     reserved_op_i,
  input  wire logic                     priv_dest_i,
  input  wire logic                     trap_i,
  input  wire logic [7:0]               trap_vec_i,
  input  wire logic                     data_misalign_i,
  input  wire logic                     data_region_i,
  input  wire logic                     cpu_init_pin_i,
  input  wire logic [14:0]              irq_pin_i,
  input  wire logic                     nmi_pin_i,
  input  wire logic                     rt_exec_i,
  input  wire logic [31:0]              rt_target_i,
  output logic                          take_o,
  output logic [31:0]                   take_addr_o,
  output logic [7:0]                    take_vector_o,
  output logic                          return_o,
  output logic [31:0]                   return_addr_o,
  output logic                          return_skip_o,
  output logic [3:0]                    level_o,
  output logic                          accept_enable_o,
  output logic                          user_mode_o
);
  // --------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0]  strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic [7:0] vec_of(input logic [4:0] idx,
                                        input logic [7:0] tv);
    case (idx)
      eiu_pkg::SRC_INIT:  vec_of = 8'h00;
      eiu_pkg::SRC_FETCH: vec_of = `EIU_VEC_FETCH;
      eiu_pkg::SRC_MISBR: vec_of = `EIU_VEC_MISBR;
      eiu_pkg::SRC_RESOP: vec_of = `EIU_VEC_RESOP;
      eiu_pkg::SRC_PRIV:  vec_of = `EIU_VEC_PRIV;
      eiu_pkg::SRC_BPT:   vec_of = `EIU_VEC_BPT;
      eiu_pkg::SRC_TRAP:  vec_of = tv;
      eiu_pkg::SRC_MDATA: vec_of = `EIU_VEC_MDATA;
      eiu_pkg::SRC_DREG:  vec_of = `EIU_VEC_DREG;
      eiu_pkg::SRC_NMI:   vec_of = `EIU_VEC_NMI;
      default:            vec_of = `EIU_VEC_IRQ_BASE + {4'h0, line_of(idx)};
    endcase
  endfunction

  function automatic logic [3:0] line_of(input logic [4:0] idx);
    logic [4:0] d;
    d = `EIU_IRQ_LAST_IDX + 5'h01 - idx;
    return d[3:0];
  endfunction

  function automatic logic is_irq(input logic [4:0] idx);
    return idx >= eiu_pkg::SRC_IRQ15;
  endfunction

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  eiu_pkg::eiu_psr_s  psr;
  eiu_pkg::eiu_psr_s  saved;
  eiu_pkg::eiu_word_t vbase;
  eiu_pkg::eiu_word_t bpaddr;
  eiu_pkg::eiu_word_t retaddr;
  logic               sys_pend;
  logic               init_pend;
  logic               init_last;
  logic               md_pend;
  logic               dr_pend;
  logic [4:0]         take_src;
  logic               take_sys;
  logic [16:0]        pins_s;
  logic               sync_ok;
  logic               async_ok;
  logic               take_now;
  logic [7:0]         sel_vec;

  eiu_sel_if #(.N(25)) sel ();

  eiu_prio #(.N(25)) u_prio (
    .sel (sel.arb)
  );

  eiu_sync #(.W(17)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({nmi_pin_i, cpu_init_pin_i, irq_pin_i}),
    .q_o     (pins_s)
  );

  assign level_o         = psr.pl;
  assign accept_enable_o = psr.em;
  assign user_mode_o     = psr.user;

  // --------------------------------------------------------------------
  // Request vector
  // --------------------------------------------------------------------
  // The cycle after a dispatch is closed so that one event is taken once.
  assign async_ok = !take_o && !sys_pend;
  assign sync_ok  = async_ok && instr_valid_i;

  assign sel.req[eiu_pkg::SRC_INIT]  = init_pend && async_ok;
  assign sel.req[eiu_pkg::SRC_FETCH] = sync_ok && fetch_fault_i &&
                                       !nullify_i;
  assign sel.req[eiu_pkg::SRC_MISBR] = sync_ok && ind_jump_i &&
                                       (|jump_target_i[1:0]) &&
                                       !nullify_i;
  assign sel.req[eiu_pkg::SRC_RESOP] = sync_ok && reserved_op_i &&
                                       !nullify_i;
  assign sel.req[eiu_pkg::SRC_PRIV]  = sync_ok && psr.user && !nullify_i &&
                                       (priv_dest_i || (trap_i &&
                                       trap_vec_i <= `EIU_USER_TRAP_MAX));
  assign sel.req[eiu_pkg::SRC_BPT]   = sync_ok && psr.em && psr.breakpoint_trap_enable &&
                                       exec_pc_i == bpaddr;
  assign sel.req[eiu_pkg::SRC_TRAP]  = sync_ok && trap_i &&
                                       !nullify_i;
  assign sel.req[eiu_pkg::SRC_MDATA] = async_ok && md_pend && psr.em;
  assign sel.req[eiu_pkg::SRC_DREG]  = async_ok && dr_pend && psr.em;
  assign sel.req[eiu_pkg::SRC_NMI]   = async_ok && NMI_USED &&
                                       pins_s[16];

  for (genvar k = 0; k < 15; k++) begin : g_irq
    // Slot 10+k serves line 15-k.
    assign sel.req[10+k] = async_ok && psr.em && IRQ_USED[14-k] &&
                           pins_s[14-k] &&
                           (psr.pl < 4'(15 - k));
  end

  assign take_now = sys_pend || sel.hit;
  assign sel_vec  = vec_of(sel.idx, trap_vec_i);

  // --------------------------------------------------------------------
  // Pending requests
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      sys_pend  <= 1'b1;
      init_pend <= 1'b0;
      init_last <= 1'b0;
    end else begin
      sys_pend  <= 1'b0;
      init_last <= pins_s[15];
      init_pend <= (pins_s[15] && !init_last) || (init_pend &&
                   !(sel.hit && sel.idx == eiu_pkg::SRC_INIT));
    end
  end

  // A new fault in the cycle of its acceptance stays pending.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      md_pend <= 1'b0;
      dr_pend <= 1'b0;
    end else begin
      md_pend <= data_misalign_i || (md_pend && !(!sys_pend && sel.hit &&
                 sel.idx == eiu_pkg::SRC_MDATA));
      dr_pend <= data_region_i || (dr_pend && !(!sys_pend && sel.hit &&
                 sel.idx == eiu_pkg::SRC_DREG));
    end
  end

  // --------------------------------------------------------------------
  // Dispatch and return
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      take_o        <= 1'b0;
      take_addr_o   <= `EIU_RESET_ADDR;
      take_vector_o <= 8'h00;
      take_src      <= 5'h00;
      take_sys      <= 1'b0;
    end else begin
      take_o   <= take_now;
      take_sys <= sys_pend;
      if (sys_pend) begin
        take_addr_o   <= `EIU_RESET_ADDR;
        take_vector_o <= 8'h00;
        take_src      <= 5'h00;
      end else if (sel.hit) begin
        take_addr_o   <= vbase | {20'h00000, sel_vec, 4'h0};
        take_vector_o <= sel_vec;
        take_src      <= sel.idx;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      return_o      <= 1'b0;
      return_addr_o <= 32'h00000000;
      return_skip_o <= 1'b0;
    end else begin
      return_o <= rt_exec_i && !take_now;
      if (rt_exec_i && !take_now) begin
        return_addr_o <= rt_target_i;
        return_skip_o <= saved.nullify;
      end
    end
  end

  // --------------------------------------------------------------------
  // Register bus
  // --------------------------------------------------------------------
  logic                   aw_full;
  logic                   w_full;
  logic [`EIU_AXI_AW-1:0] aw_addr;
  logic [31:0]            w_data;
  logic [3:0]             w_strb;
  logic                   wr_fire;
  logic                   next_aw_full;
  logic                   next_w_full;
  logic                   next_rvalid;

  assign wr_fire      = aw_full && w_full && !bvalid_o;
  assign next_aw_full = !wr_fire && (aw_full || (awvalid_i && awready_o));
  assign next_w_full  = !wr_fire && (w_full || (wvalid_i && wready_o));
  assign next_rvalid  = (rvalid_o && !rready_i) || (arvalid_i && arready_o);

  function automatic logic wr_at(input logic [`EIU_AXI_AW-1:0] ofs);
    return wr_fire && aw_addr == ofs;
  endfunction

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_full   <= 1'b0;
      w_full    <= 1'b0;
      awready_o <= 1'b0;
      wready_o  <= 1'b0;
      aw_addr   <= '0;
      w_data    <= 32'h00000000;
      w_strb    <= 4'h0;
      bvalid_o  <= 1'b0;
      bresp_o   <= `EIU_RESP_OKAY;
    end else begin
      aw_full   <= next_aw_full;
      w_full    <= next_w_full;
      awready_o <= !next_aw_full;
      wready_o  <= !next_w_full;
      if (awvalid_i && awready_o) begin
        aw_addr <= awaddr_i;
      end
      if (wvalid_i && wready_o) begin
        w_data <= wdata_i;
        w_strb <= wstrb_i;
      end
      if (wr_fire) begin
        bvalid_o <= 1'b1;
        bresp_o  <= (aw_addr <= `EIU_OFS_CAUSE && aw_addr[1:0] == 2'h0) ?
                    `EIU_RESP_OKAY : `EIU_RESP_SLVERR;
      end else if (bready_i) begin
        bvalid_o <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      arready_o <= 1'b0;
      rvalid_o  <= 1'b0;
      rdata_o   <= 32'h00000000;
      rresp_o   <= `EIU_RESP_OKAY;
    end else begin
      arready_o <= !next_rvalid;
      rvalid_o  <= next_rvalid;
      if (arvalid_i && arready_o) begin
        rresp_o <= `EIU_RESP_OKAY;
        case (araddr_i)
          `EIU_OFS_PSR:     rdata_o <= {24'h000000, psr};
          `EIU_OFS_SAVED:   rdata_o <= {24'h000000, saved};
          `EIU_OFS_VBASE:   rdata_o <= vbase;
          `EIU_OFS_BPADDR:  rdata_o <= bpaddr;
          `EIU_OFS_RETADDR: rdata_o <= retaddr;
          `EIU_OFS_CAUSE:   rdata_o <= {16'h0000, md_pend, dr_pend,
                                        init_pend, 5'h00, take_vector_o};
          default: begin
            rdata_o <= 32'h00000000;
            rresp_o <= `EIU_RESP_SLVERR;
          end
        endcase
      end
    end
  end

  // --------------------------------------------------------------------
  // Status, saved status and addresses
  // --------------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      psr <= `EIU_PSR_RESET;
    end else if (sys_pend) begin
      psr <= `EIU_PSR_RESET;
    end else if (sel.hit) begin
      psr.em <= 1'b0;
      if (is_irq(sel.idx)) begin
        psr.pl <= line_of(sel.idx);
      end else if (sel.idx != eiu_pkg::SRC_TRAP) begin
        psr.pl <= `EIU_PL_MAX;
      end
    end else if (rt_exec_i) begin
      psr <= saved;
    end else if (wr_at(`EIU_OFS_PSR)) begin
      psr <= 8'(merge({24'h000000, psr}, w_data, w_strb));
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      saved <= 8'h00;
    end else if (!sys_pend && sel.hit) begin
      saved         <= psr;
      saved.nullify <= nullify_i;
    end else if (wr_at(`EIU_OFS_SAVED)) begin
      saved <= 8'(merge({24'h000000, saved}, w_data, w_strb));
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      vbase  <= 32'h00000000;
      bpaddr <= 32'h00000000;
    end else begin
      if (wr_at(`EIU_OFS_VBASE)) begin
        vbase <= merge(vbase, w_data, w_strb);
      end
      if (wr_at(`EIU_OFS_BPADDR)) begin
        bpaddr <= merge(bpaddr, w_data, w_strb);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      retaddr <= 32'h00000000;
    end else if (sys_pend) begin
      retaddr <= 32'h00000000;
    end else if (sel.hit) begin
      if (sel.idx == eiu_pkg::SRC_BPT) begin
        retaddr <= bpaddr;
      end else if (sel.idx == eiu_pkg::SRC_TRAP) begin
        retaddr <= exec_pc_i + 32'h00000004;
      end else begin
        retaddr <= exec_pc_i;
      end
    end else if (wr_at(`EIU_OFS_RETADDR)) begin
      retaddr <= merge(retaddr, w_data, w_strb);
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  a_reset_vector: assert property (!$past(rst_n_i) |=> take_o &&
    take_addr_o == 32'h0 && level_o == 4'hf) else $error("reset vector");
  a_dispatch_or: assert property (take_o && !take_sys |->
    take_addr_o == (vbase | {20'h0, take_vector_o, 4'h0}))
    else $error("dispatch address");
  a_irq_level: assert property (take_o && is_irq(take_src) |->
    level_o == take_vector_o[3:0] && $past(level_o) < level_o)
    else $error("interrupt level");
  a_fault_level: assert property (take_o && take_src <= 5'h05 &&
    !take_sys |-> level_o == 4'hf) else $error("fault level");
  a_em_cleared: assert property (take_o && !take_sys |->
    !accept_enable_o && saved.em == $past(psr.em)) else $error("em");
  a_irq_gate: assert property (take_o && is_irq(take_src) |->
    $past(psr.em)) else $error("interrupt gate");
  a_md_hold: assert property (md_pend && !psr.em && !rt_exec_i &&
    !wr_fire |=> md_pend) else $error("misaligned data dropped");
  a_bpt_saved: assert property (take_o && take_src == 5'h05
    |-> retaddr == bpaddr) else $error("breakpoint address");
  a_null_fetch: assert property (sync_ok && nullify_i &&
    !psr.em |=> !(take_o && take_src <= 5'h04 && take_src != 5'h00))
    else $error("nullified fault");
  a_rt_restore: assert property (rt_exec_i && !take_now |=>
    return_o && psr == $past(saved) && return_skip_o == $past(saved.nullify))
    else $error("return restore");

  c_irq:  cover property (take_o && is_irq(take_src));
  c_bpt:  cover property (take_o && take_src == 5'h05);
  c_trap: cover property (take_o && take_src == 5'h06);
  c_skip: cover property (return_o && return_skip_o);
endmodule // eiu_top

// ---- tb/eiu_partner.sv ----
// Pin-side requester model: seven sources on the odd interrupt lines.
// Assumes the bench commands each source level on clk_i.
`timescale 1ns/100ps
module eiu_partner (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic [14:0] raise_i,
  output logic      [14:0] irq_o
);
  // Unwired lines never rise, whatever the bench commands.
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      irq_o <= '0;
    end else begin
      irq_o <= raise_i & 15'h5554;
    end
  end
endmodule // eiu_partner

// ---- tb/tb.sv ----
// Bench for the exception unit: register bus, pipeline and pin sources.
// Assumes eiu_top and eiu_partner are compiled before it.
`timescale 1ns/100ps
module tb;
  logic        clk_i, rst_n_i, awvalid_i, wvalid_i, bready_i, arvalid_i;
  logic        rready_i, instr_valid_i, nullify_i, fetch_fault_i;
  logic        ind_jump_i, reserved_op_i, priv_dest_i, trap_i, rt_exec_i;
  logic        data_misalign_i, data_region_i, cpu_init_pin_i, nmi_pin_i;
  logic        awready_o, wready_o, bvalid_o, arready_o, rvalid_o;
  logic        take_o, return_o, return_skip_o, accept_enable_o;
  logic        user_mode_o;
  logic [7:0]  awaddr_i, araddr_i, trap_vec_i, take_vector_o;
  logic [31:0] wdata_i, exec_pc_i, jump_target_i, rt_target_i, rdata_o;
  logic [31:0] take_addr_o, return_addr_o;
  logic [14:0] irq_pin_i, raise;
  logic [3:0]  wstrb_i, level_o;
  logic [1:0]  bresp_o, rresp_o;
  int          failures, cmp_count, cyc;
  localparam logic [31:0] vb = 32'h0000_3000;

  eiu_top u_dut (.*);
  eiu_partner u_pin (.clk_i, .rst_n_i, .raise_i(raise), .irq_o(irq_pin_i));

  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      failures++;
      close_out();
    end
  end

  // ----------------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------------
  task automatic chk(input logic [33:0] s, input logic [33:0] e);
    cmp_count++;
    if (s !== e) begin
      failures++;
      $display("ERROR t=%0t seen %h exp %h", $time, s, e);
    end
  endtask

  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    {awaddr_i, wdata_i, awvalid_i, wvalid_i, bready_i} <= {a, d, 3'h7};
    do begin
      @(posedge clk_i);
      if (awready_o) awvalid_i <= 1'b0;
      if (wready_o) wvalid_i <= 1'b0;
    end while (bvalid_o !== 1'b1);
    chk(bresp_o, 2'h0);
    bready_i <= 1'b0;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] e,
                    input logic [1:0] r);
    {araddr_i, arvalid_i, rready_i} <= {a, 2'h3};
    do begin
      @(posedge clk_i);
      if (arready_o) arvalid_i <= 1'b0;
    end while (rvalid_o !== 1'b1);
    chk({rresp_o, rdata_o}, {r, e});
    rready_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // Strobes one execute cycle, then watches ten cycles for a dispatch.
  task automatic go(input logic t, input logic [7:0] v);
    logic f;
    f = 1'b0;
    instr_valid_i <= 1'b1;
    @(posedge clk_i);
    {instr_valid_i, nullify_i, fetch_fault_i, ind_jump_i, reserved_op_i,
     trap_i, data_misalign_i, data_region_i, priv_dest_i} <= '0;
    repeat (10) begin
      @(posedge clk_i);
      if (!f && take_o === 1'b1) begin
        f = 1'b1;
        chk(take_addr_o, vb | {20'h0, v, 4'h0});
        chk(take_vector_o, v);
      end
    end
    chk(f, t);
  endtask

  // ----------------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------------
  task automatic s_reset;
    repeat (16) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    chk({take_o, take_addr_o}, {1'b1, 32'h0});
    chk(level_o, 4'hf);
    rd(8'h00, 32'h0f, 2'h0);
    rd(8'h40, 32'h0, 2'h2);
    wr(8'h08, vb);
  endtask

  task automatic s_sync;
    {exec_pc_i, fetch_fault_i} <= {32'h0000_0100, 1'b1};
    go(1'b1, 8'h01);
    chk({level_o, accept_enable_o}, 5'h1e);
    rd(8'h10, 32'h100, 2'h0);
    {fetch_fault_i, nullify_i} <= 2'h3;
    go(1'b0, 8'h01);
    {ind_jump_i, jump_target_i} <= {1'b1, 32'h0000_0102};
    go(1'b1, 8'h02);
    {reserved_op_i, trap_i, trap_vec_i} <= {2'h3, 8'hff};
    go(1'b1, 8'h03);
    {trap_i, trap_vec_i} <= {1'b1, 8'hff};
    go(1'b1, 8'hff);
  endtask

  task automatic s_irq;
    wr(8'h00, 32'h13);
    raise <= 15'h0004;
    go(1'b0, 8'h23);
    raise <= 15'h0014;
    go(1'b1, 8'h25);
    chk({level_o, accept_enable_o}, 5'h0a);
    raise <= 15'h0004;
    wr(8'h04, 32'h93);
    {rt_exec_i, rt_target_i} <= {1'b1, 32'h0000_0400};
    @(posedge clk_i);
    rt_exec_i <= 1'b0;
    @(posedge clk_i);
    chk({return_o, return_addr_o}, {1'b1, 32'h400});
    chk({return_skip_o, level_o}, 5'h13);
    go(1'b0, 8'h23);
    raise <= 15'h0;
  endtask

  task automatic s_data;
    wr(8'h00, 32'h00);
    data_misalign_i <= 1'b1;
    go(1'b0, 8'h05);
    rd(8'h14, 32'h0000_8025, 2'h0);
    wr(8'h00, 32'h10);
    repeat (4) @(posedge clk_i);
    chk({take_vector_o, take_addr_o}, {8'h05, vb | 32'h50});
  endtask

  // Breakpoint, user-mode faults, data region fault and soft reset.
  task automatic s_more;
    wr(8'h0c, 32'h200);
    wr(8'h00, 32'h30);
    {exec_pc_i, nullify_i} <= {32'h0000_0200, 1'b1};
    go(1'b1, 8'h08);
    rd(8'h10, 32'h200, 2'h0);
    wr(8'h00, 32'h40);
    chk(user_mode_o, 1'b1);
    {priv_dest_i, nullify_i} <= 2'h3;
    go(1'b0, 8'h04);
    priv_dest_i <= 1'b1;
    go(1'b1, 8'h04);
    {trap_i, trap_vec_i} <= {1'b1, 8'h40};
    go(1'b1, 8'h04);
    {trap_i, trap_vec_i} <= {1'b1, 8'h41};
    go(1'b1, 8'h41);
    wr(8'h00, 32'h10);
    data_region_i <= 1'b1;
    go(1'b1, 8'h06);
    rd(8'h10, 32'h200, 2'h0);
    cpu_init_pin_i <= 1'b1;
    go(1'b1, 8'h00);
    chk(level_o, 4'hf);
    cpu_init_pin_i <= 1'b0;
  endtask

  initial begin
    {rst_n_i, awvalid_i, wvalid_i, bready_i, arvalid_i, rready_i} = '0;
    {instr_valid_i, nullify_i, fetch_fault_i, ind_jump_i, rt_exec_i} = '0;
    {reserved_op_i, priv_dest_i, trap_i, data_misalign_i} = '0;
    {data_region_i, cpu_init_pin_i, nmi_pin_i, raise} = '0;
    {awaddr_i, araddr_i, trap_vec_i, wdata_i, exec_pc_i} = '0;
    {jump_target_i, rt_target_i, wstrb_i} = {64'h0, 4'hf};
    s_reset();
    s_sync();
    s_irq();
    s_data();
    s_more();
    close_out();
  end
endmodule // tb
